/* File: rtl/kbd_link_pkg.sv */
package kbd_link_pkg;
  localparam int CLK_MHZ = 250;
  // Bit timing in microseconds
  localparam int CELL_US = 440;
  localparam int HALF_US = 220;
  localparam int FIRST_US = 310;
  localparam int CARRIER_KHZ = 40;
  localparam int HALF_CYC = HALF_US * CLK_MHZ;
  localparam int CELL_CYC = CELL_US * CLK_MHZ;
  localparam int FIRST_CYC = FIRST_US * CLK_MHZ;
  // Half period of the 40 kHz carrier, rounded down
  localparam int CARR_HALF_CYC = (CLK_MHZ * 1000) / (2 * CARRIER_KHZ);
  localparam int VOTES = 5;
  localparam int VOTE_MAJ = 3;
  localparam int DATA_BITS = 8;
  localparam int STOP_CELLS = 11;
  localparam int BREAK_BIT = 7;
  localparam logic [7:0] BREAK_OFS = 8'h80;
  localparam int DATA_PORT_BIT = 6;
  localparam int TIMER_CHANNEL = 1;
endpackage

/* File: rtl/kbd_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface kbd_link_if;
  logic ir_keyboard_rx_n;
  logic cable_data;
  logic cable_attached_n;
  modport keyboard (
    output ir_keyboard_rx_n,
    output cable_data,
    output cable_attached_n
  );
  modport receiver (
    input ir_keyboard_rx_n,
    input cable_data,
    input cable_attached_n
  );
endinterface
`default_nettype wire

/* File: rtl/kbd_link_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module kbd_link_tx #(
  parameter int HALF_CYC = kbd_link_pkg::HALF_CYC,
  parameter int STOP_CELLS = kbd_link_pkg::STOP_CELLS,
  parameter int CARR_HALF_CYC = kbd_link_pkg::CARR_HALF_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_key_valid,
  input wire logic [6:0] i_key_code,
  input wire logic i_key_release,
  input wire logic i_use_cable,
  output logic o_key_ready,
  kbd_link_if.keyboard link
);
  typedef enum {S_IDLE, S_SEND, S_GAP} tx_state_e;
  localparam int NCELLS = kbd_link_pkg::DATA_BITS + 3;
  tx_state_e st_q, st_d;
  logic [NCELLS-1:0] frame_q, frame_d;
  logic [4:0] cell_q, cell_d;
  logic half_q, half_d;
  logic [31:0] tmr_q, tmr_d;
  logic [15:0] car_q, car_d;
  logic carrier_q, carrier_d;
  logic level_d;
  logic ready_q, ready_d;
  logic cable_d;
  logic [7:0] code;
  logic bitv;

  always_comb begin
    // Break code is make code plus hex 80
    // RULE13: break offset
    code = i_key_release ? ({1'b0, i_key_code} + kbd_link_pkg::BREAK_OFS)
                         : {1'b0, i_key_code};
    bitv = frame_q[0];
    st_d = st_q;
    frame_d = frame_q;
    cell_d = cell_q;
    half_d = half_q;
    tmr_d = tmr_q;
    ready_d = 1'b0;
    cable_d = i_use_cable;
    level_d = 1'b1;
    car_d = car_q + 16'h0001;
    carrier_d = carrier_q;
    if (car_q == 16'(CARR_HALF_CYC - 1)) begin
      car_d = 16'h0000;
      carrier_d = ~carrier_q;
    end
    case (st_q)
      S_IDLE: begin
        level_d = 1'b0;
        ready_d = 1'b1;
        if (i_key_valid && ready_q) begin
          // RULE12: make and break words
          // RULE17: start, data LSB first, parity, stop
          frame_d = {1'b1, ~^code, code, 1'b1};
          st_d = S_SEND;
          cell_d = 5'h00;
          half_d = 1'b0;
          tmr_d = 32'h0;
          ready_d = 1'b0;
        end
      end
      S_SEND: begin
        // RULE16: one high then low, zero low then high
        level_d = half_q ? ~bitv : bitv;
        // Stop cell held low, no edge to look like a start
        if (cell_q == 5'(NCELLS - 1)) begin
          level_d = 1'b0;
        end
        tmr_d = tmr_q + 32'h1;
        if (tmr_q == 32'(HALF_CYC - 1)) begin
          tmr_d = 32'h0;
          half_d = ~half_q;
          if (half_q) begin
            frame_d = frame_q >> 1;
            cell_d = cell_q + 5'h01;
            if (cell_q == 5'(NCELLS - 1)) begin
              st_d = S_GAP;
              cell_d = 5'h00;
            end
          end
        end
      end
      S_GAP: begin
        // RULE18: eleven idle stop cells
        level_d = 1'b0;
        tmr_d = tmr_q + 32'h1;
        if (tmr_q == 32'(HALF_CYC - 1)) begin
          tmr_d = 32'h0;
          half_d = ~half_q;
          if (half_q) begin
            cell_d = cell_q + 5'h01;
            if (cell_q == 5'(STOP_CELLS - 1)) begin
              st_d = S_IDLE;
            end
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= S_IDLE;
      frame_q <= '0;
      cell_q <= 5'h00;
      half_q <= 1'b0;
      tmr_q <= 32'h0;
      car_q <= 16'h0000;
      carrier_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      frame_q <= frame_d;
      cell_q <= cell_d;
      half_q <= half_d;
      tmr_q <= tmr_d;
      car_q <= car_d;
      carrier_q <= carrier_d;
      ready_q <= ready_d;
    end
  end

  logic ir_q, cdat_q, catt_n_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ir_q <= 1'b1;
      cdat_q <= 1'b0;
      catt_n_q <= 1'b1;
    end else begin
      cdat_q <= level_d & cable_d;
      catt_n_q <= ~cable_d;
      // RULE9: high bits as 40 kHz bursts
      // RULE11: same frame on both paths
      ir_q <= ~(level_d & carrier_d & ~cable_d);
    end
  end

  assign o_key_ready = ready_q;
  assign link.ir_keyboard_rx_n = ir_q;
  assign link.cable_data = cdat_q;
  assign link.cable_attached_n = catt_n_q;
endmodule
`default_nettype wire

/* File: rtl/kbd_link_rx.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: start edge raises nonmaskable interrupt
// RULE2: wait for start trailing edge
// RULE3: first sample 310 us later
// RULE4: then sample every 220 us
// RULE5: five-sample majority per half bit
// RULE6: phase error if halves not complementary
// RULE7: parity error unless word odd
// RULE8: any error sounds a short tone
// RULE9: 40 kHz carrier demodulated to baseband
// RULE10: cable attached disables infrared path
// RULE11: same frame on both paths
// RULE12: keyboard sends make and break codes
// RULE13: break code is make plus 80
// RULE14: test tone drives diagnostic emitter
// RULE15: data bit six, timer channel one
// RULE16: 440 us biphase cell
// RULE17: start, eight data LSB first, parity, stop
// RULE18: eleven stop cells between words
// RULE19: reset returns to idle, clean
// RULE20: present code with error flags
module kbd_link_rx #(
  parameter int HALF_CYC = kbd_link_pkg::HALF_CYC,
  parameter int FIRST_CYC = kbd_link_pkg::FIRST_CYC,
  parameter int CARR_HALF_CYC = kbd_link_pkg::CARR_HALF_CYC,
  parameter int TONE_CYC = 4 * kbd_link_pkg::CELL_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_test_enable,
  input wire logic i_nmi_ack,
  kbd_link_if.receiver link,
  output logic o_nmi,
  output logic o_code_valid,
  output logic [7:0] o_code,
  output logic o_phase_err,
  output logic o_parity_err,
  output logic o_alarm,
  output logic o_receiver_test_tone
);
  typedef enum {S_IDLE, S_TRAIL, S_SAMPLE} rx_state_e;
  localparam int NB = kbd_link_pkg::DATA_BITS + 1;
  localparam int SUB_CYC = HALF_CYC / kbd_link_pkg::VOTES;
  localparam int FIRST_SUB = FIRST_CYC - (kbd_link_pkg::VOTES / 2) * SUB_CYC;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers and demodulation
  logic [1:0] ir_s_q, cab_s_q, con_s_q;
  logic [15:0] hold_q, hold_d;
  logic data_q, data_d;
  logic ir_hi;

  always_comb begin
    ir_hi = 1'b0;
    hold_d = hold_q;
    // RULE9: stretch carrier bursts to baseband
    if (!ir_s_q[1]) begin
      hold_d = 16'(2 * CARR_HALF_CYC + CARR_HALF_CYC);
    end else if (hold_q != 16'h0000) begin
      hold_d = hold_q - 16'h0001;
    end
    ir_hi = hold_q != 16'h0000;
    // RULE10: cable attached masks infrared
    // RULE11: one deserializer for both
    data_d = con_s_q[1] ? ir_hi : cab_s_q[1];
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ir_s_q <= 2'b11;
      cab_s_q <= 2'b00;
      con_s_q <= 2'b11;
      hold_q <= 16'h0000;
      data_q <= 1'b0;
    end else begin
      ir_s_q <= {ir_s_q[0], link.ir_keyboard_rx_n};
      cab_s_q <= {cab_s_q[0], link.cable_data};
      con_s_q <= {con_s_q[0], link.cable_attached_n};
      hold_q <= hold_d;
      data_q <= data_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Deserializer
  rx_state_e st_q, st_d;
  logic [31:0] tmr_q, tmr_d;
  logic [2:0] vote_n_q, vote_n_d;
  logic [2:0] ones_q, ones_d;
  logic half_q, half_d;
  logic first_q, first_d;
  logic [3:0] bit_q, bit_d;
  logic [NB-1:0] sh_q, sh_d;
  logic ph_q, ph_d;
  logic prev_q, nmi_q, nmi_d;
  logic val_q, val_d;
  logic [7:0] code_q, code_d;
  logic pe_q, pe_d, pa_q, pa_d;
  logic [31:0] tone_q, tone_d;
  logic alarm_q, alarm_d;
  logic lvl;
  logic [2:0] ones_n;

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    vote_n_d = vote_n_q;
    ones_d = ones_q;
    half_d = half_q;
    first_d = first_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ph_d = ph_q;
    nmi_d = nmi_q & ~i_nmi_ack;
    val_d = 1'b0;
    code_d = code_q;
    pe_d = pe_q;
    pa_d = pa_q;
    tone_d = tone_q;
    alarm_d = 1'b0;
    ones_n = ones_q + {2'b00, data_q};
    lvl = ones_n >= 3'(kbd_link_pkg::VOTE_MAJ);
    if (tone_q != 32'h0) begin
      tone_d = tone_q - 32'h1;
      alarm_d = 1'b1;
    end
    case (st_q)
      S_IDLE: begin
        // RULE1: rising start edge
        if (data_q && !prev_q) begin
          nmi_d = 1'b1;
          st_d = S_TRAIL;
        end
      end
      S_TRAIL: begin
        // RULE2: start trailing edge
        if (!data_q) begin
          st_d = S_SAMPLE;
          // RULE3: 310 us to first half centre
          tmr_d = 32'(FIRST_SUB);
          vote_n_d = 3'h0;
          ones_d = 3'h0;
          half_d = 1'b0;
          bit_d = 4'h0;
          ph_d = 1'b0;
        end
      end
      S_SAMPLE: begin
        // RULE15: one shared sampling timer
        if (tmr_q != 32'h0) begin
          tmr_d = tmr_q - 32'h1;
        end else begin
          // RULE4: 220 us per half cell
          tmr_d = 32'(SUB_CYC - 1);
          vote_n_d = vote_n_q + 3'h1;
          ones_d = ones_n;
          // RULE5: majority of five
          if (vote_n_q == 3'(kbd_link_pkg::VOTES - 1)) begin
            vote_n_d = 3'h0;
            ones_d = 3'h0;
            half_d = ~half_q;
            if (!half_q) begin
              first_d = lvl;
            end else begin
              // RULE6: halves must differ
              ph_d = ph_q | (first_q == lvl);
              sh_d = {first_q, sh_q[NB-1:1]};
              bit_d = bit_q + 4'h1;
              if (bit_q == 4'(NB - 1)) begin
                st_d = S_IDLE;
                // RULE20: publish word and flags
                val_d = 1'b1;
                code_d = sh_d[7:0];
                pe_d = ph_q | (first_q == lvl);
                // RULE7: odd parity
                pa_d = ~^sh_d;
                // RULE8: error tone
                if (ph_q || (first_q == lvl) || !(^sh_d)) begin
                  tone_d = 32'(TONE_CYC);
                end
              end
            end
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // RULE19: clean idle after reset
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= S_IDLE;
      tmr_q <= 32'h0;
      vote_n_q <= 3'h0;
      ones_q <= 3'h0;
      half_q <= 1'b0;
      first_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= '0;
      ph_q <= 1'b0;
      prev_q <= 1'b1;
      nmi_q <= 1'b0;
      val_q <= 1'b0;
      code_q <= 8'h00;
      pe_q <= 1'b0;
      pa_q <= 1'b0;
      tone_q <= 32'h0;
      alarm_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      vote_n_q <= vote_n_d;
      ones_q <= ones_d;
      half_q <= half_d;
      first_q <= first_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ph_q <= ph_d;
      prev_q <= data_q;
      nmi_q <= nmi_d;
      val_q <= val_d;
      code_q <= code_d;
      pe_q <= pe_d;
      pa_q <= pa_d;
      tone_q <= tone_d;
      alarm_q <= alarm_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Diagnostic emitter tone
  logic [15:0] tc_q, tc_d;
  logic tt_q, tt_d;
  always_comb begin
    tc_d = tc_q + 16'h0001;
    tt_d = tt_q;
    // RULE14: test tone on request
    if (!i_test_enable) begin
      tc_d = 16'h0000;
      tt_d = 1'b0;
    end else if (tc_q == 16'(CARR_HALF_CYC - 1)) begin
      tc_d = 16'h0000;
      tt_d = ~tt_q;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tc_q <= 16'h0000;
      tt_q <= 1'b0;
    end else begin
      tc_q <= tc_d;
      tt_q <= tt_d;
    end
  end

  assign o_nmi = nmi_q;
  assign o_code_valid = val_q;
  assign o_code = code_q;
  assign o_phase_err = pe_q;
  assign o_parity_err = pa_q;
  assign o_alarm = alarm_q;
  assign o_receiver_test_tone = tt_q;
endmodule
`default_nettype wire

/* File: verification/kbd_link_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module kbd_link_sva #(
  parameter int HALF_CYC = 50,
  parameter int CARR_HALF_CYC = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic ir_keyboard_rx_n,
  input wire logic cable_data,
  input wire logic cable_attached_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [15:0] run_q, run_d, hi_q, hi_d, lo_q, lo_d;
  logic prev_q;
  logic idle;
  //////////////////////////////
  // Run lengths on the wire
  assign idle = run_q >= 16'(4 * HALF_CYC);
  always_comb begin
    run_d = run_q + {15'h0000, run_q != 16'h0FFF};
    if (cable_data != prev_q) begin
      run_d = 16'h0000;
    end
    hi_d = cable_data ? hi_q + 16'h0001 : 16'h0000;
    lo_d = ir_keyboard_rx_n ? 16'h0000 : lo_q + 16'h0001;
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      run_q <= 16'h0FFF;
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
      prev_q <= 1'b0;
    end else begin
      run_q <= run_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      prev_q <= cable_data;
    end
  end
  //////////////////////////////
  sequence start_half;
    cable_data ##(HALF_CYC - 1) cable_data ##1 !cable_data;
  endsequence
  reset_idle_a: assert property (
    $fell(i_rst) |-> ir_keyboard_rx_n && cable_attached_n && !cable_data)
    else $error("line not idle after reset");
  cable_quiet_a: assert property (
    cable_attached_n |-> !cable_data)
    else $error("cable data active in infrared mode");
  ir_quiet_a: assert property (
    !cable_attached_n |-> ir_keyboard_rx_n)
    else $error("infrared active with cable attached");
  half_grid_a: assert property (
    (cable_data != prev_q) |-> idle || ((run_q + 1) % HALF_CYC == 0))
    else $error("cable edge off the half cell grid");
  high_run_a: assert property (
    cable_data |-> hi_q < 2 * HALF_CYC)
    else $error("cable high longer than one cell");
  burst_len_a: assert property (
    !ir_keyboard_rx_n |-> lo_q < CARR_HALF_CYC)
    else $error("carrier phase too long");
  mode_idle_a: assert property (
    $changed(cable_attached_n) |-> !cable_data && ir_keyboard_rx_n)
    else $error("path switched inside a frame");
  start_frame_a: assert property (
    $rose(cable_data) && idle |-> start_half)
    else $error("start bit not one half high then low");
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int HC = 50;
  localparam int CH = 4;
  localparam int TC = 100;
  localparam logic [6:0] KC [4] = '{7'h01, 7'h01, 7'h7F, 7'h2E};
  localparam logic KR [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  localparam logic KCAB [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic i_ref_clk, i_rst, key_valid, key_release, use_cable, key_ready;
  logic [6:0] key_code;
  logic test_en, nmi_ack, nmi, valid, phase_err, parity_err, alarm, tone;
  logic nmi_b, valid_b, phase_b, parity_b, alarm_b, raw;
  logic [7:0] code, code_b;
  int num_errors, checks;
  kbd_link_if link_a();
  kbd_link_if link_b();
  assign link_b.cable_data = raw;
  assign link_b.ir_keyboard_rx_n = 1'b1;
  assign link_b.cable_attached_n = 1'b0;
  kbd_link_tx #(.HALF_CYC(HC), .CARR_HALF_CYC(CH)) i_kbd_link_tx (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_key_valid(key_valid), .i_key_code(key_code),
    .i_key_release(key_release), .i_use_cable(use_cable),
    .o_key_ready(key_ready), .link(link_a));
  kbd_link_rx #(.HALF_CYC(HC), .FIRST_CYC(70), .CARR_HALF_CYC(CH),
    .TONE_CYC(TC)) i_kbd_link_rx (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_test_enable(test_en), .i_nmi_ack(nmi_ack), .link(link_a),
    .o_nmi(nmi), .o_code_valid(valid), .o_code(code),
    .o_phase_err(phase_err), .o_parity_err(parity_err), .o_alarm(alarm),
    .o_receiver_test_tone(tone));
  kbd_link_rx #(.HALF_CYC(HC), .FIRST_CYC(70), .CARR_HALF_CYC(CH),
    .TONE_CYC(TC)) i_kbd_link_rx_b (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_test_enable(1'b0), .i_nmi_ack(1'b0), .link(link_b),
    .o_nmi(nmi_b), .o_code_valid(valid_b), .o_code(code_b),
    .o_phase_err(phase_b), .o_parity_err(parity_b), .o_alarm(alarm_b),
    .o_receiver_test_tone());
  kbd_link_sva #(.HALF_CYC(HC), .CARR_HALF_CYC(CH)) i_kbd_link_sva (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .ir_keyboard_rx_n(link_a.ir_keyboard_rx_n),
    .cable_data(link_a.cable_data),
    .cable_attached_n(link_a.cable_attached_n));
  //////////////////////////////
  task automatic cmp1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic cmp8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic send_key(input logic [6:0] c, input logic r,
                          input logic cab);
    while (key_ready !== 1'b1) @(negedge i_ref_clk);
    use_cable = cab;
    key_code = c;
    key_release = r;
    key_valid = 1'b1;
    // Ready stood high, so the next rising edge takes it
    @(negedge i_ref_clk);
    key_valid = 1'b0;
  endtask
  task automatic wait_word(input bit b);
    int n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while ((b ? valid_b : valid) !== 1'b1 && n < 4000);
    cmp1("code_valid", 1'b1, b ? valid_b : valid);
  endtask
  // Glitch of five cycles hits at most one vote
  task automatic raw_half(input logic v, input bit g);
    for (int k = 0; k < HC; k++) begin
      @(negedge i_ref_clk);
      raw = (g && k >= 19 && k < 24) ? ~v : v;
    end
  endtask
  task automatic raw_test(input logic [7:0] d, input logic pf,
                          input int bad, input bit g);
    logic [9:0] bits;
    bits = {(~^d) ^ pf, d, 1'b1};
    fork
      begin
        for (int i = 0; i < 10; i++) begin
          raw_half(bits[i], g && i > 0);
          raw_half(i == bad ? bits[i] : ~bits[i], g);
        end
        for (int i = 0; i < 12; i++) raw_half(1'b0, 1'b0);
      end
      begin
        wait_word(1'b1);
        cmp1("phase_err_b", bad < 10, phase_b);
        if (bad > 9) cmp8("code_b", d, code_b);
        if (bad > 9) cmp1("parity_err_b", pf, parity_b);
        repeat (3) @(negedge i_ref_clk);
        cmp1("alarm_b", pf | (bad < 10), alarm_b);
        repeat (TC + 5) @(negedge i_ref_clk);
        cmp1("alarm_b", 1'b0, alarm_b);
      end
    join
    $display("raw word %h done", d);
  endtask
  //////////////////////////////
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
  initial begin
    logic t;
    logic [7:0] k;
    i_rst = 1'b1;
    key_valid = 1'b0;
    key_code = 7'h00;
    key_release = 1'b0;
    use_cable = 1'b1;
    test_en = 1'b0;
    nmi_ack = 1'b0;
    raw = 1'b0;
    repeat (16) @(negedge i_ref_clk);
    i_rst = 1'b0;
    cmp1("nmi", 1'b0, nmi);
    cmp8("code", 8'h00, code);
    cmp1("phase_err", 1'b0, phase_err);
    cmp1("parity_err", 1'b0, parity_err);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      send_key(KC[i], KR[i], KCAB[i]);
      wait_word(1'b0);
      cmp8("code", {1'b0, KC[i]} + (KR[i] ? 8'h80 : 8'h00), code);
      cmp1("phase_err", 1'b0, phase_err);
      cmp1("parity_err", 1'b0, parity_err);
      cmp1("nmi", 1'b1, nmi);
      nmi_ack = 1'b1;
      @(negedge i_ref_clk);
      nmi_ack = 1'b0;
      @(negedge i_ref_clk);
      cmp1("nmi", 1'b0, nmi);
      cmp1("alarm", 1'b0, alarm);
      $display("key word %0d done", i);
    end
    raw_test(8'hA5, 1'b0, 99, 1'b1);
    raw_test(8'h3C, 1'b0, 3, 1'b0);
    raw_test(8'h00, 1'b1, 99, 1'b0);
    test_en = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    for (int r = 0; r < 2; r++) begin
      t = tone;
      k = 8'h00;
      do begin
        @(negedge i_ref_clk);
        k++;
      end while (tone === t && k < 8'h32);
    end
    cmp8("tone_half", 8'(CH), k);
    $display("tone test done");
    wrap_up();
  end
endmodule
`default_nettype wire
